// File: cfg_hdr_defines.vh
// Purpose: constants for the configuration header and base address logic
// Assumes: dword-aligned configuration accesses with byte offsets below 200h
// Notes: offsets are byte offsets inside one function's configuration space
`ifndef CFG_HDR_DEFINES_VH
`define CFG_HDR_DEFINES_VH

// header offsets (byte address of the dword)
`define OFS_CLASS_REV 12'h008
`define OFS_CLS_LAT_HDR 12'h00c
`define OFS_CSR_MEM_BASE 12'h010
`define OFS_CSR_IO_BASE 12'h014
`define OFS_FLASH_BASE 12'h018
`define OFS_CARD_INFO 12'h028
`define OFS_BOOT_ROM_BASE 12'h030
`define OFS_FUNC1_BANK 12'h100

// class code fields
`define CLASS_BASE_NET 8'h02
`define CLASS_SUB_ETH 8'h00
`define CLASS_PROG_IF 8'h00
`define REVISION_ID 8'h00

// cache line size accepted values
`define CLS_8_DW 8'h08
`define CLS_16_DW 8'h10
`define CLS_BIT_8 3
`define CLS_BIT_16 4

// header type values
`define HDR_SINGLE 8'h00
`define HDR_MULTI 8'h80

// base address writable masks and fixed low bits
`define CSR_MEM_MASK 32'hfffff000
`define CSR_MEM_FIXED 32'h00000000
`define CSR_IO_MASK 32'hffffffc0
`define CSR_IO_FIXED 32'h00000001
`define FLASH_MASK 32'hfffe0000
`define FLASH_FIXED 32'h00000000
`define ROM_MASK 32'hfff00000
`define ROM_EN_BIT 0
`define ROM_WR_MASK 32'hfff00001
`define ROM_FIXED 32'h00000000
`define RESET_BASE 32'h00000000

// card information structure
`define CIS_OFFSET 32'h00010000
`define CIS_MASK 32'hffff0000
`define CIS_PTR_HI 28'h0001000
`define CIS_PTR_LO 4'h3

`endif

// File: bar_reg.v
// Purpose: one base address register with byte-enabled writes
// Assumes: writes come from the configuration port on the same clock
// Notes: only bits set in WR_MASK store; FIXED supplies hard-wired low bits
`timescale 1ns/100ps
`include "cfg_hdr_defines.vh"

module bar_reg #(
  parameter [31:0] WR_MASK = 32'hffffffff,
  parameter [31:0] FIXED = 32'h00000000
) (
  input wire clk_sys,
  input wire reset,
  input wire wr,
  input wire [3:0] byte_en,
  input wire [31:0] wdata,
  output wire [31:0] value
);

  // reset value held at full width so each lane takes its own byte
  localparam [31:0] RESET_VALUE = `RESET_BASE;

  reg [31:0] base_r;

  // each byte lane updates on its own enable; fixed-zero bits never store
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_lane
      always @(posedge clk_sys) begin
        if (reset) begin
          base_r[b*8+7:b*8] <= RESET_VALUE[b*8+7:b*8];
        end else if (wr && byte_en[b]) begin
          base_r[b*8+7:b*8] <= wdata[b*8+7:b*8] & WR_MASK[b*8+7:b*8]; // [R10]
        end
      end
    end
  endgenerate

  // low type bits are constants so sizing software sees the window [R8]
  assign value = (base_r & WR_MASK) | FIXED;

endmodule // bar_reg

// File: ownership_timer.v
// Purpose: counts bus clocks of master ownership against the latency timer
// Assumes: master_active is high for each clock the device owns the bus
// Notes: expired stays high until ownership ends
`timescale 1ns/100ps

module ownership_timer (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] limit,
  input wire master_active,
  output reg expired
);

  reg [7:0] count_r;

  // reload while idle, count down while owning the bus [R5]
  always @(posedge clk_sys) begin
    if (reset) begin
      count_r <= 8'h00;
      expired <= 1'b0;
    end else if (!master_active) begin
      count_r <= limit;
      expired <= 1'b0;
    end else begin
      if (count_r != 8'h00) begin
        count_r <= count_r - 8'h01;
      end
      expired <= (count_r == 8'h00) || (count_r == 8'h01); // [R5]
    end
  end

endmodule // ownership_timer

// File: cfg_header.v
// Purpose: configuration header registers and window decode for a network function
// Assumes: one bus clock; eeprom loader and bus logic share it; card mode strap is a pin
// Notes: second function's bank is forwarded, not held here
//
// Functional notes
// R1 - class code reads network base class, ethernet subclass, zero interface byte
// R2 - cache line size accepts only 8 or 16; others read zero, disable mwi
// R3 - bit 3 set only by writing 08h, bit 4 only by 10h; others zero
// R4 - boot firmware programs cache line size; driver should not write it
// R5 - latency timer limits bus ownership in clocks while mastering
// R6 - header type reads 00h single, 80h combined, chosen from eeprom
// R7 - combined device presents second function bank at offset 100h
// R8 - bar bit 0 read-only: zero for memory, one for i/o
// R9 - i/o bar is 32 bits, bit 1 reads zero, upper bits decode
// R10 - only window-size upper bits writable; lower bits fixed zero for sizing
// R11 - csr memory window 4 kbytes, non-prefetchable, anywhere in 32-bit space
// R12 - csr i/o window decodes 64 bytes; software picks memory or i/o
// R13 - flash bar always claims 128 kbyte window, flash present or not
// R14 - card mode serves card info from flash base plus 64 kbyte
// R15 - boot rom bar claims 1 mbyte, backed by 128 kbyte local memory
// R16 - boot-disable set makes boot rom bar read all zeros
// R17 - modem select high while boot enabled until first rom access, then low; code does this only when combined,
//   also driving it low while rom bar bit 0 is clear, and holds it high in single mode
// R18 - card info pointer zero in pci mode; 1000h and 3h in card mode
// R19 - csr memory, csr i/o, flash occupy first three bar slots
`timescale 1ns/100ps
`include "cfg_hdr_defines.vh"

module cfg_header (
  input wire clk_sys,
  input wire reset,
  // configuration access port
  input wire cfg_rd,
  input wire cfg_wr,
  input wire [11:0] cfg_addr,
  input wire [3:0] cfg_byte_en,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata,
  output reg cfg_rd_valid,
  output wire cfg_ready,
  // second function forwarding
  output reg fn1_cfg_rd,
  output reg fn1_cfg_wr,
  output reg [11:0] fn1_cfg_addr,
  output reg [3:0] fn1_cfg_byte_en,
  output reg [31:0] fn1_cfg_wdata,
  input wire [31:0] fn1_cfg_rdata,
  // eeprom word contents, valid on ee_load
  input wire ee_load,
  input wire ee_combo,
  input wire ee_boot_disable,
  // card mode strap pin
  input wire card_mode_pin,
  // command register enables
  input wire mem_space_en,
  input wire io_space_en,
  // target address phase
  input wire tgt_valid,
  input wire tgt_is_io,
  input wire [31:0] tgt_addr,
  output reg hit_csr_mem,
  output reg hit_csr_io,
  output reg hit_flash,
  output reg hit_card_info,
  output reg hit_boot_rom,
  // master side
  input wire master_active,
  output wire latency_expired,
  output reg mwi_enable,
  output reg [7:0] cache_line_dwords,
  // modem chip select
  output reg modem_chip_select_n
);

  // window match, used for every bar decode
  function win_hit;
    input [31:0] addr;
    input [31:0] base;
    input [31:0] mask;
    begin
      win_hit = ((addr & mask) == (base & mask));
    end
  endfunction

  reg card_sync1_r;
  reg card_sync2_r;
  reg ee_loaded_r;
  reg combo_r;
  reg boot_disable_r;
  reg rom_used_r;
  reg cls_8_r;
  reg cls_16_r;
  reg [7:0] latency_r;
  reg [31:0] rdata_nxt;
  reg fn1_rd_pend_r;
  wire [31:0] csr_mem_value;
  wire [31:0] csr_io_value;
  wire [31:0] flash_value;
  wire [31:0] rom_raw_value;
  wire [31:0] rom_value;
  wire [31:0] card_info_value;
  wire [7:0] cls_value;
  wire [7:0] header_value;
  wire wr_local;
  wire in_fn1;
  wire wr_csr_mem;
  wire wr_csr_io;
  wire wr_flash;
  wire wr_rom;
  wire rom_enabled;

  // card mode strap crosses in from a pin
  always @(posedge clk_sys) begin
    if (reset) begin
      card_sync1_r <= 1'b0;
      card_sync2_r <= 1'b0;
    end else begin
      card_sync1_r <= card_mode_pin;
      card_sync2_r <= card_sync1_r;
    end
  end

  // eeprom derived settings, caught once the loader reports completion
  always @(posedge clk_sys) begin
    if (reset) begin
      ee_loaded_r <= 1'b0;
      combo_r <= 1'b0;
      boot_disable_r <= 1'b0;
    end else if (ee_load) begin
      ee_loaded_r <= 1'b1;
      combo_r <= ee_combo; // [R6]
      boot_disable_r <= ee_boot_disable; // [R16]
    end
  end

  // accesses before the eeprom is read must be retried by the bus logic
  assign cfg_ready = ee_loaded_r;

  // offsets at and above 100h belong to the second function when combined
  assign in_fn1 = (cfg_addr >= `OFS_FUNC1_BANK); // [R7]
  assign wr_local = cfg_wr && ee_loaded_r && !in_fn1;
  assign wr_csr_mem = wr_local && (cfg_addr == `OFS_CSR_MEM_BASE); // [R19]
  assign wr_csr_io = wr_local && (cfg_addr == `OFS_CSR_IO_BASE); // [R19]
  assign wr_flash = wr_local && (cfg_addr == `OFS_FLASH_BASE); // [R19]
  assign wr_rom = wr_local && (cfg_addr == `OFS_BOOT_ROM_BASE);

  // csr memory window: 4 kbyte, memory, 32-bit, non-prefetchable
  bar_reg #(
    .WR_MASK(`CSR_MEM_MASK),
    .FIXED(`CSR_MEM_FIXED)
  ) u_csr_mem_bar (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr(wr_csr_mem),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .value(csr_mem_value)
  ); // [R11]

  // csr i/o window: 64 bytes, bit 0 one, bit 1 zero
  bar_reg #(
    .WR_MASK(`CSR_IO_MASK),
    .FIXED(`CSR_IO_FIXED)
  ) u_csr_io_bar (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr(wr_csr_io),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .value(csr_io_value)
  ); // [R9] [R12]

  // flash window is always claimed even with no flash fitted
  bar_reg #(
    .WR_MASK(`FLASH_MASK),
    .FIXED(`FLASH_FIXED)
  ) u_flash_bar (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr(wr_flash),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .value(flash_value)
  ); // [R13]

  // boot rom window: 1 mbyte, bit 0 is the software rom enable
  bar_reg #(
    .WR_MASK(`ROM_WR_MASK),
    .FIXED(`ROM_FIXED)
  ) u_rom_bar (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr(wr_rom),
    .byte_en(cfg_byte_en),
    .wdata(cfg_wdata),
    .value(rom_raw_value)
  ); // [R15]

  // boot-disable hides the rom bar completely so nothing gets allocated
  assign rom_value = boot_disable_r ? 32'h00000000 : rom_raw_value; // [R16]
  assign rom_enabled = rom_value[`ROM_EN_BIT];

  // card info pointer only means something in card mode
  assign card_info_value = card_sync2_r ? {`CIS_PTR_HI, `CIS_PTR_LO} : 32'h00000000; // [R18]

  // only the two legal cache line bits can ever read back as one
  assign cls_value = {3'b000, cls_16_r, cls_8_r, 3'b000}; // [R3]
  assign header_value = combo_r ? `HDR_MULTI : `HDR_SINGLE; // [R6]

  // cache line size and latency timer writes
  always @(posedge clk_sys) begin
    if (reset) begin
      cls_8_r <= 1'b0;
      cls_16_r <= 1'b0;
      latency_r <= 8'h00;
    end else if (wr_local && (cfg_addr == `OFS_CLS_LAT_HDR)) begin
      if (cfg_byte_en[0]) begin
        // a bad value clears the register rather than keeping the old size
        cls_8_r <= (cfg_wdata[7:0] == `CLS_8_DW); // [R2] [R3]
        cls_16_r <= (cfg_wdata[7:0] == `CLS_16_DW); // [R2] [R3]
      end
      if (cfg_byte_en[1]) begin
        latency_r <= cfg_wdata[15:8]; // [R5]
      end
    end
  end

  // mwi only with a supported line size
  always @(posedge clk_sys) begin
    if (reset) begin
      mwi_enable <= 1'b0;
      cache_line_dwords <= 8'h00;
    end else begin
      mwi_enable <= cls_8_r | cls_16_r; // [R2]
      cache_line_dwords <= cls_value;
    end
  end

  // bus ownership limit while acting as master
  ownership_timer u_owner_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .limit(latency_r),
    .master_active(master_active),
    .expired(latency_expired)
  ); // [R5]

  // read data selection for the local bank
  always @* begin
    rdata_nxt = 32'h00000000;
    if (cfg_addr == `OFS_CLASS_REV) begin
      rdata_nxt = {`CLASS_BASE_NET, `CLASS_SUB_ETH, `CLASS_PROG_IF, `REVISION_ID}; // [R1]
    end else if (cfg_addr == `OFS_CLS_LAT_HDR) begin
      rdata_nxt = {8'h00, header_value, latency_r, cls_value}; // [R2] [R6]
    end else if (cfg_addr == `OFS_CSR_MEM_BASE) begin
      rdata_nxt = csr_mem_value; // [R8] [R19]
    end else if (cfg_addr == `OFS_CSR_IO_BASE) begin
      rdata_nxt = csr_io_value; // [R8] [R19]
    end else if (cfg_addr == `OFS_FLASH_BASE) begin
      rdata_nxt = flash_value; // [R19]
    end else if (cfg_addr == `OFS_CARD_INFO) begin
      rdata_nxt = card_info_value; // [R18]
    end else if (cfg_addr == `OFS_BOOT_ROM_BASE) begin
      rdata_nxt = rom_value; // [R16]
    end
  end

  // forward second-function cycles; a single function drops writes and answers reads with zero
  always @(posedge clk_sys) begin
    if (reset) begin
      fn1_cfg_rd <= 1'b0;
      fn1_cfg_wr <= 1'b0;
      fn1_cfg_addr <= 12'h000;
      fn1_cfg_byte_en <= 4'h0;
      fn1_cfg_wdata <= 32'h00000000;
    end else begin
      fn1_cfg_rd <= cfg_rd && ee_loaded_r && in_fn1 && combo_r; // [R7]
      fn1_cfg_wr <= cfg_wr && ee_loaded_r && in_fn1 && combo_r; // [R7]
      fn1_cfg_addr <= cfg_addr - `OFS_FUNC1_BANK;
      fn1_cfg_byte_en <= cfg_byte_en;
      fn1_cfg_wdata <= cfg_wdata;
    end
  end

  // read answer: local reads in one cycle, forwarded ones in three
  always @(posedge clk_sys) begin
    if (reset) begin
      cfg_rdata <= 32'h00000000;
      cfg_rd_valid <= 1'b0;
      fn1_rd_pend_r <= 1'b0;
    end else begin
      fn1_rd_pend_r <= fn1_cfg_rd;
      cfg_rd_valid <= 1'b0;
      if (fn1_rd_pend_r) begin
        cfg_rdata <= fn1_cfg_rdata; // [R7]
        cfg_rd_valid <= 1'b1;
      end else if (cfg_rd && ee_loaded_r && in_fn1 && !combo_r) begin
        cfg_rdata <= 32'h00000000;
        cfg_rd_valid <= 1'b1;
      end else if (cfg_rd && ee_loaded_r && !in_fn1) begin
        cfg_rdata <= rdata_nxt;
        cfg_rd_valid <= 1'b1;
      end
    end
  end

  // target decode; software may use either csr window [R12]
  always @(posedge clk_sys) begin
    if (reset) begin
      hit_csr_mem <= 1'b0;
      hit_csr_io <= 1'b0;
      hit_flash <= 1'b0;
      hit_card_info <= 1'b0;
      hit_boot_rom <= 1'b0;
    end else begin
      hit_csr_mem <= tgt_valid && !tgt_is_io && mem_space_en &&
        win_hit(tgt_addr, csr_mem_value, `CSR_MEM_MASK); // [R11]
      hit_csr_io <= tgt_valid && tgt_is_io && io_space_en &&
        win_hit(tgt_addr, csr_io_value, `CSR_IO_MASK); // [R12]
      hit_flash <= tgt_valid && !tgt_is_io && mem_space_en &&
        win_hit(tgt_addr, flash_value, `FLASH_MASK) &&
        !(card_sync2_r && tgt_addr[16]); // [R13]
      // upper half of the flash window carries card info in card mode
      hit_card_info <= tgt_valid && !tgt_is_io && mem_space_en && card_sync2_r &&
        win_hit(tgt_addr, flash_value | `CIS_OFFSET, `CIS_MASK); // [R14]
      hit_boot_rom <= tgt_valid && !tgt_is_io && mem_space_en && rom_enabled &&
        win_hit(tgt_addr, rom_value, `ROM_MASK); // [R15]
    end
  end

  // first rom access hands the local bus to the modem in combined mode
  always @(posedge clk_sys) begin
    if (reset) begin
      rom_used_r <= 1'b0;
    end else if (hit_boot_rom) begin
      rom_used_r <= 1'b1; // [R17]
    end
  end

  // select stays high while the rom owns the local bus
  always @(posedge clk_sys) begin
    if (reset) begin
      modem_chip_select_n <= 1'b1;
    end else begin
      modem_chip_select_n <= !(combo_r && (rom_used_r || boot_disable_r || !rom_enabled)); // [R17]
    end
  end

endmodule // cfg_header

// File: cfg_header_chk.sv
// Purpose: port-level checks of the configuration header block
// Assumes: one clock, synchronous active-high reset
// Notes: read checks apply to local offsets only
`timescale 1ns/100ps
module cfg_header_chk (
  input wire clk_sys,
  input wire reset,
  input wire cfg_rd,
  input wire cfg_wr,
  input wire [11:0] cfg_addr,
  input wire [3:0] cfg_byte_en,
  input wire [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata,
  input wire cfg_ready,
  input wire fn1_cfg_rd,
  input wire [11:0] fn1_cfg_addr,
  input wire master_active,
  input wire latency_expired,
  input wire mwi_enable,
  input wire [7:0] cache_line_dwords,
  input wire hit_flash,
  input wire hit_card_info
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // accepted requests only; refused ones have no effect
  wire rd_ok = cfg_rd && cfg_ready;
  wire cls_bad = cfg_wr && cfg_ready && cfg_addr == 12'h00c && cfg_byte_en[0]
    && cfg_wdata[7:0] != 8'h08 && cfg_wdata[7:0] != 8'h10;
  property p_class;
    rd_ok && cfg_addr == 12'h008 |=> cfg_rdata == 32'h02000000;
  endproperty
  a_class: assert property (p_class) else $error("class code wrong");
  property p_cls_bad;
    cls_bad |-> ##2 (cache_line_dwords == 8'h00 && !mwi_enable);
  endproperty
  a_cls_bad: assert property (p_cls_bad) else $error("bad line size kept");
  property p_cls_vals;
    cache_line_dwords == 8'h00 || cache_line_dwords == 8'h08 || cache_line_dwords == 8'h10;
  endproperty
  a_cls_vals: assert property (p_cls_vals) else $error("line size value illegal");
  property p_lat_hold;
    latency_expired && master_active |=> latency_expired;
  endproperty
  a_lat_hold: assert property (p_lat_hold) else $error("expiry dropped early");
  property p_lat_end;
    !master_active |=> !latency_expired;
  endproperty
  a_lat_end: assert property (p_lat_end) else $error("expiry after ownership");
  property p_hdr;
    rd_ok && cfg_addr == 12'h00c |=> cfg_rdata[23:16] == 8'h00 || cfg_rdata[23:16] == 8'h80;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header type illegal");
  property p_fwd;
    fn1_cfg_rd |-> $past(rd_ok) && fn1_cfg_addr == $past(cfg_addr) - 12'h100;
  endproperty
  a_fwd: assert property (p_fwd) else $error("second bank forward wrong");
  property p_csr_memory_base;
    rd_ok && cfg_addr == 12'h010 |=> cfg_rdata[11:0] == 12'h000;
  endproperty
  a_csr_memory_base: assert property (p_csr_memory_base) else $error("memory window low bits");
  property p_csr_io_base;
    rd_ok && cfg_addr == 12'h014 |=> cfg_rdata[5:0] == 6'h01;
  endproperty
  a_csr_io_base: assert property (p_csr_io_base) else $error("io window low bits");
  property p_flash_memory_base;
    rd_ok && cfg_addr == 12'h018 |=> cfg_rdata[16:0] == 17'h00000;
  endproperty
  a_flash_memory_base: assert property (p_flash_memory_base) else $error("flash window low bits");
  property p_card;
    hit_card_info |-> !hit_flash;
  endproperty
  a_card: assert property (p_card) else $error("card info also hit flash");
  property p_cis;
    rd_ok && cfg_addr == 12'h028 |=> cfg_rdata == 32'h0 || cfg_rdata == 32'h00010003;
  endproperty
  a_cis: assert property (p_cis) else $error("card info pointer wrong");
  c_fwd: cover property (fn1_cfg_rd);
  c_card: cover property (hit_card_info);
  c_lat: cover property (latency_expired && master_active);
endmodule // cfg_header_chk
bind cfg_header cfg_header_chk cfg_header_chk_inst (.*);

// File: cfg_host_model.sv
// Purpose: host bridge issuing configuration cycles
// Assumes: requests are single pulses taken at one edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/100ps
module cfg_host_model (
  input wire clk_sys,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [11:0] cfg_addr,
  output logic [3:0] cfg_byte_en,
  output logic [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata,
  input wire cfg_rd_valid
);
  // idle bus at time zero
  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 12'h000;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
  end
  task wr(input [11:0] a, input [31:0] d, input [3:0] be);
    @(posedge clk_sys) #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    @(posedge clk_sys) #1;
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask
  // bounded wait, so a missing answer returns unknown data
  task rd(input [11:0] a, output [31:0] d);
    integer n;
    @(posedge clk_sys) #1;
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk_sys) #1;
    cfg_rd = 1'b0;
    n = 0;
    while (cfg_rd_valid !== 1'b1 && n < 8) begin
      @(posedge clk_sys) #1;
      n = n + 1;
    end
    d = (n < 8) ? cfg_rdata : 32'hx;
  endtask
endmodule // cfg_host_model

// File: pci_config_header_bars_tb_top.sv
// Purpose: self-checking bench of the configuration header block
// Assumes: host model drives the config port, bench drives the rest
// Notes: the bench acts as boot firmware, so it sets the line size
`timescale 1ns/100ps
module pci_config_header_bars_tb_top;
  logic clk_sys, reset, cfg_rd, cfg_wr, cfg_rd_valid, cfg_ready, fn1_cfg_rd, fn1_cfg_wr;
  logic [11:0] cfg_addr, fn1_cfg_addr;
  logic [3:0] cfg_byte_en, fn1_cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, fn1_cfg_wdata, fn1_cfg_rdata, tgt_addr, rv;
  logic ee_load, ee_combo, ee_boot_disable, card_mode_pin, mem_space_en, io_space_en;
  logic tgt_valid, tgt_is_io, hit_csr_mem, hit_csr_io, hit_flash, hit_card_info, hit_boot_rom;
  logic master_active, latency_expired, mwi_enable, modem_chip_select_n;
  logic [7:0] cache_line_dwords;
  integer miscompares = 0;
  integer cmp_count = 0;
  cfg_header cfg_header_inst (.*);
  cfg_host_model cfg_host_model_inst (.*);
  // clock at 125 mhz
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] g, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task eel(input c, input b);
    @(posedge clk_sys) #1;
    ee_combo = c;
    ee_boot_disable = b;
    ee_load = 1'b1;
    @(posedge clk_sys) #1;
    ee_load = 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // hits come back one cycle after the address phase
  task tgt(input io, input [31:0] a, input [4:0] e);
    @(posedge clk_sys) #1;
    tgt_valid = 1'b1;
    tgt_is_io = io;
    tgt_addr = a;
    @(posedge clk_sys) #1;
    tgt_valid = 1'b0;
    tgt_addr = ~a;
    chk({hit_csr_mem, hit_csr_io, hit_flash, hit_card_info, hit_boot_rom}, e);
  endtask
  task automatic t_cls;
    logic [7:0] v [4] = '{8'h08, 8'h18, 8'h10, 8'h0c};
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      e = (v[i] == 8'h08 || v[i] == 8'h10) ? v[i] : 8'h00;
      cfg_host_model_inst.wr(12'h00c, {24'h0, v[i]}, 4'h1);
      cfg_host_model_inst.rd(12'h00c, rv);
      chk({rv[7:0], cache_line_dwords, mwi_enable}, {e, e, e != 8'h00});
    end
    $display("line size test done");
  endtask
  task t_lat;
    integer n;
    cfg_host_model_inst.wr(12'h00c, 32'h00000500, 4'h2);
    cfg_host_model_inst.rd(12'h00c, rv);
    chk(rv[15:8], 8'h05);
    master_active = 1'b1;
    n = 0;
    while (latency_expired !== 1'b1 && n < 40) begin
      @(posedge clk_sys) #1;
      n = n + 1;
    end
    chk(n >= 3 && n <= 7, 1);
    master_active = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(latency_expired, 0);
    $display("latency test done");
  endtask
  task t_hdr;
    eel(1'b1, 1'b0);
    cfg_host_model_inst.rd(12'h008, rv);
    chk(rv, 32'h02000000);
    cfg_host_model_inst.rd(12'h00c, rv);
    chk(rv[23:16], 8'h80);
    cfg_host_model_inst.rd(12'h108, rv);
    chk(rv, 32'h5a5ac3c3);
    cfg_host_model_inst.wr(12'h104, 32'h12345678, 4'h3);
    chk({fn1_cfg_wr, fn1_cfg_addr, fn1_cfg_byte_en}, {1'b1, 12'h004, 4'h3});
    chk(fn1_cfg_wdata, 32'h12345678);
    eel(1'b0, 1'b0);
    cfg_host_model_inst.rd(12'h00c, rv);
    chk(rv[23:16], 8'h00);
    // a single function answers second-bank reads itself with zero
    cfg_host_model_inst.rd(12'h108, rv);
    chk(rv, 32'h0);
    cfg_host_model_inst.wr(12'h104, 32'h12345678, 4'h3);
    chk(fn1_cfg_wr, 0);
    $display("header test done");
  endtask
  // all ones written to each slot returns the sizing pattern
  task automatic t_bars;
    logic [11:0] o [4] = '{12'h010, 12'h014, 12'h018, 12'h030};
    logic [31:0] m [4] = '{32'hfffff000, 32'hffffffc1, 32'hfffe0000, 32'hfff00001};
    for (int i = 0; i < 4; i++) begin
      cfg_host_model_inst.wr(o[i], 32'hffffffff, 4'hf);
      cfg_host_model_inst.rd(o[i], rv);
      chk(rv, m[i]);
    end
    $display("base register test done");
  endtask
  task t_decode;
    cfg_host_model_inst.wr(12'h010, 32'h40000000, 4'hf);
    cfg_host_model_inst.wr(12'h014, 32'h00001000, 4'hf);
    cfg_host_model_inst.wr(12'h018, 32'h80000000, 4'hf);
    mem_space_en = 1'b1;
    io_space_en = 1'b1;
    tgt(1'b0, 32'h40000ffc, 5'h10);
    tgt(1'b0, 32'h40001000, 5'h00);
    tgt(1'b1, 32'h0000103c, 5'h08);
    tgt(1'b1, 32'h00001040, 5'h00);
    tgt(1'b0, 32'h8001fffc, 5'h04);
    cfg_host_model_inst.rd(12'h028, rv);
    chk(rv, 32'h0);
    card_mode_pin = 1'b1;
    repeat (4) @(posedge clk_sys);
    tgt(1'b0, 32'h80010000, 5'h02);
    tgt(1'b0, 32'h8000fffc, 5'h04);
    cfg_host_model_inst.rd(12'h028, rv);
    chk(rv, 32'h00010003);
    card_mode_pin = 1'b0;
    io_space_en = 1'b0;
    tgt(1'b1, 32'h00001000, 5'h00);
    $display("decode test done");
  endtask
  task t_rom;
    eel(1'b1, 1'b0);
    cfg_host_model_inst.wr(12'h030, 32'h00100000, 4'hf);
    repeat (2) @(posedge clk_sys);
    #1 chk(modem_chip_select_n, 0);
    cfg_host_model_inst.wr(12'h030, 32'h00100001, 4'hf);
    repeat (2) @(posedge clk_sys);
    #1 chk(modem_chip_select_n, 1);
    tgt(1'b0, 32'h001ffffc, 5'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk(modem_chip_select_n, 0);
    eel(1'b1, 1'b1);
    cfg_host_model_inst.rd(12'h030, rv);
    chk(rv, 32'h0);
    tgt(1'b0, 32'h001ffffc, 5'h00);
    $display("boot rom test done");
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    {ee_load, ee_combo, ee_boot_disable, card_mode_pin, mem_space_en} = 5'h0;
    {io_space_en, tgt_valid, tgt_is_io, master_active} = 4'h0;
    tgt_addr = 32'h0;
    fn1_cfg_rdata = 32'h5a5ac3c3;
    repeat (16) @(posedge clk_sys);
    #1 reset = 1'b0;
    // ready low, select high, master outputs quiet out of reset
    chk({cfg_ready, modem_chip_select_n, mwi_enable, latency_expired}, 4'h4);
    eel(1'b0, 1'b0);
    chk(cfg_ready, 1);
    t_cls;
    t_lat;
    t_hdr;
    t_bars;
    t_decode;
    t_rom;
    final_report;
  end
  // watchdog, well past the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares = miscompares + 1;
    final_report;
  end
endmodule // pci_config_header_bars_tb_top
